/* design/eef_top.sv */
/*
   Emulated byte storage writer: key registers, offset, data and control
   registers on a classic Wishbone slave, and a sequencer that drives the
   flash macro and stops the processor clock while an operation runs.
   Assumes the flash macro acts on the request levels it is given and that
   the register bus keeps running on clk_i while the processor clock is off.
*/
`timescale 1ns/100ps

// What this block does
// - Storage window 3840 bytes at fixed base
// - Enabled only for key pair 1010 and 0101
// - Key registers: four write-only bits, reset zero
// - Twelve-bit offset, readable, resets to all ones
// - Erase bit starts a 512-byte page erase
// - Program bit writes data byte at offset
// - Write-only timing code sets duration, reset 08h
// - Write-only data byte register, resets zero
// - Processor clock stopped while operation runs
// - Erase fills selected valid page with FFh
module eef_top #(
   parameter logic       LARGE_VARIANT     = 1'b1,
   parameter int         ADR_W             = 12,
   parameter int         PROG_STEP_CYCLES  = eef_pkg::PROG_STEP_CYCLES,
   parameter int         ERASE_STEP_CYCLES = eef_pkg::ERASE_STEP_CYCLES
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  cpu_clk_run_o,
   output logic                  flash_prog_o,
   output logic                  flash_erase_o,
   output logic      [15:0]      flash_addr_o,
   output logic      [7:0]       flash_wdata_o,
   output logic                  busy_o
);
   localparam logic [15:0] BASE = LARGE_VARIANT ? eef_pkg::BASE_LARGE : eef_pkg::BASE_SMALL;

   logic [3:0]  key_nibble_one_reg;
   logic [3:0]  key_nibble_two_reg;
   logic [7:0]  offset_low_reg;
   logic [3:0]  offset_high_reg;
   logic [3:0]  operation_timing_code_reg;
   logic [7:0]  program_byte_value_reg;
   logic        refused_reg;
   logic        refused_next;
   logic [3:0]  timing_code_next;
   eef_pkg::eef_state_t state_reg;

   logic        access;
   logic        wr_stb;
   logic        enabled;
   logic [11:0] storage_offset;
   logic        sel_key_one;
   logic        sel_key_two;
   logic        sel_off_low;
   logic        sel_off_high;
   logic        sel_control;
   logic        sel_wr_byte;
   logic        sel_status;
   logic        ctl_write;
   logic        erase_req;
   logic        prog_req;
   logic        page_ok;
   logic        byte_ok;
   logic        start_erase;
   logic        start_prog;
   logic [31:0] steps;
   logic [31:0] load_count;
   logic        op_done;
   logic [31:0] rd_data;

   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_stb = access && wb_we_i && wb_sel_i[0];

   // Registers sit on word boundaries; an address with its low bits set hits nothing.
   function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] idx);
      hit = (a == ADR_W'({idx, 2'b00}));
   endfunction

   // One decoder feeds the write strobes and the read mux, so they cannot disagree.
   always_comb begin
      sel_key_one  = 1'b0;
      sel_key_two  = 1'b0;
      sel_off_low  = 1'b0;
      sel_off_high = 1'b0;
      sel_control  = 1'b0;
      sel_wr_byte  = 1'b0;
      sel_status   = 1'b0;
      if (hit(wb_adr_i, eef_pkg::IDX_KEY_ONE)) begin
         sel_key_one = 1'b1;
      end else if (hit(wb_adr_i, eef_pkg::IDX_KEY_TWO)) begin
         sel_key_two = 1'b1;
      end else if (hit(wb_adr_i, eef_pkg::IDX_OFF_LOW)) begin
         sel_off_low = 1'b1;
      end else if (hit(wb_adr_i, eef_pkg::IDX_OFF_HIGH)) begin
         sel_off_high = 1'b1;
      end else if (hit(wb_adr_i, eef_pkg::IDX_CONTROL)) begin
         sel_control = 1'b1;
      end else if (hit(wb_adr_i, eef_pkg::IDX_WR_BYTE)) begin
         sel_wr_byte = 1'b1;
      end else if (hit(wb_adr_i, eef_pkg::IDX_STATUS)) begin
         sel_status = 1'b1;
      end
   end

   assign enabled        = (key_nibble_one_reg == eef_pkg::KEY_ONE_OPEN) &&
                           (key_nibble_two_reg == eef_pkg::KEY_TWO_OPEN);
   assign storage_offset = {offset_high_reg, offset_low_reg};

   // A request rides on the control write; its timing code comes with it.
   assign ctl_write = wr_stb && sel_control;
   assign erase_req = ctl_write && wb_dat_i[eef_pkg::CTL_ERASE_BIT]
                      && !wb_dat_i[eef_pkg::CTL_RESERVED_ZERO_BIT];
   assign prog_req  = ctl_write && wb_dat_i[eef_pkg::CTL_PROGRAM_BIT]
                      && !wb_dat_i[eef_pkg::CTL_RESERVED_ZERO_BIT];

   // Only the seven page starts inside the window may be erased.
   // An odd or out-of-range page start is refused rather than rounded down.
   assign page_ok = (offset_low_reg == eef_pkg::PAGE_LOW) && !offset_high_reg[0]
                    && (offset_high_reg <= eef_pkg::LAST_PAGE_HI);
   assign byte_ok = (storage_offset <= eef_pkg::LAST_OFFSET);

   // Erase wins when both request bits are written together.
   assign start_erase = erase_req && enabled && page_ok
                        && (state_reg == eef_pkg::ST_IDLE);
   assign start_prog  = prog_req && !erase_req && enabled && byte_ok
                        && (state_reg == eef_pkg::ST_IDLE);

   // The code that times an operation is the one written with its start bit,
   // so the register's next value is used rather than its old contents.
   assign timing_code_next = (ctl_write && state_reg == eef_pkg::ST_IDLE)
                             ? wb_dat_i[3:0] : operation_timing_code_reg;

   // Code 0 would give no time at all, so it counts as one step.
   assign steps      = (timing_code_next == 4'h0) ? 32'h1 : {28'h0, timing_code_next};
   assign load_count = erase_req ? 32'(steps * ERASE_STEP_CYCLES)
                                 : 32'(steps * PROG_STEP_CYCLES);

   eef_op_timer #(
      .CNT_W (32)
   ) u_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (start_erase || start_prog),
      .load_i  (load_count),
      .done_o  (op_done)
   );

   // Key registers hold only their low nibble and start closed.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_nibble_one_reg <= eef_pkg::RST_KEY;
         key_nibble_two_reg <= eef_pkg::RST_KEY;
      end else begin
         if (wr_stb && sel_key_one) begin
            key_nibble_one_reg <= wb_dat_i[3:0];
         end
         if (wr_stb && sel_key_two) begin
            key_nibble_two_reg <= wb_dat_i[3:0];
         end
      end
   end

   // Offset and data are frozen during an operation so the macro sees stable values.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         offset_low_reg         <= eef_pkg::RST_OFF_LOW;
         offset_high_reg        <= eef_pkg::RST_OFF_HIGH;
         program_byte_value_reg <= eef_pkg::RST_WR_BYTE;
      end else if (state_reg == eef_pkg::ST_IDLE) begin
         if (wr_stb && sel_off_low) begin
            offset_low_reg <= wb_dat_i[7:0];
         end
         if (wr_stb && sel_off_high) begin
            offset_high_reg <= wb_dat_i[3:0];
         end
         if (wr_stb && sel_wr_byte) begin
            program_byte_value_reg <= wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         operation_timing_code_reg <= eef_pkg::RST_TIMING;
      end else begin
         operation_timing_code_reg <= timing_code_next;
      end
   end

   // Sticky flag for a request that was dropped; a new refusal beats the clear.
   always_comb begin
      refused_next = refused_reg;
      if (wr_stb && sel_status
          && wb_dat_i[eef_pkg::STS_REFUSED_BIT]) begin
         refused_next = 1'b0;
      end
      if ((erase_req || prog_req) && !start_erase && !start_prog) begin
         refused_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refused_reg <= 1'b0;
      end else begin
         refused_reg <= refused_next;
      end
   end

   // Sequencer: the processor clock stays off for the whole operation.
   // A reset cuts an operation short and cannot resume it; the page may be half done.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg     <= eef_pkg::ST_IDLE;
         cpu_clk_run_o <= 1'b1;
         flash_prog_o  <= 1'b0;
         flash_erase_o <= 1'b0;
         flash_addr_o  <= '0;
         flash_wdata_o <= eef_pkg::ERASED_BYTE;
         busy_o        <= 1'b0;
      end else begin
         case (state_reg)
            eef_pkg::ST_IDLE: begin
               if (start_erase) begin
                  state_reg     <= eef_pkg::ST_ERASE;
                  flash_erase_o <= 1'b1;
                  flash_addr_o  <= BASE + {4'h0, storage_offset};
                  flash_wdata_o <= eef_pkg::ERASED_BYTE;
                  cpu_clk_run_o <= 1'b0;
                  busy_o        <= 1'b1;
               end else if (start_prog) begin
                  state_reg     <= eef_pkg::ST_PROGRAM;
                  flash_prog_o  <= 1'b1;
                  flash_addr_o  <= BASE + {4'h0, storage_offset};
                  flash_wdata_o <= program_byte_value_reg;
                  cpu_clk_run_o <= 1'b0;
                  busy_o        <= 1'b1;
               end
            end
            eef_pkg::ST_PROGRAM,
            eef_pkg::ST_ERASE: begin
               if (op_done) begin
                  state_reg     <= eef_pkg::ST_IDLE;
                  flash_prog_o  <= 1'b0;
                  flash_erase_o <= 1'b0;
                  cpu_clk_run_o <= 1'b1;
                  busy_o        <= 1'b0;
               end
            end
            default: begin
               state_reg <= eef_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Write-only registers and unmapped addresses read as zero.
   always_comb begin
      rd_data = 32'h0;
      if (sel_off_low) begin
         rd_data = {24'h0, offset_low_reg};
      end else if (sel_off_high) begin
         rd_data = {28'h0, offset_high_reg};
      end else if (sel_status) begin
         rd_data[eef_pkg::STS_BUSY_BIT]    = busy_o;
         rd_data[eef_pkg::STS_ENABLED_BIT] = enabled;
         rd_data[eef_pkg::STS_REFUSED_BIT] = refused_reg;
         rd_data[eef_pkg::STS_ERASING_BIT] = flash_erase_o;
      end
   end

   // Every access is acknowledged one cycle after it is taken, even while busy.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   // Read data stands only in the acknowledge cycle and is zero at all other times.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else begin
         wb_dat_o <= access ? rd_data : 32'h0;
      end
   end
endmodule // eef_top

/* design/eef_pkg.sv */
/*
   Constants for the emulated storage flash writer: register indices, field
   positions, reset values, key values, storage geometry and timing figures.
   Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package eef_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_KEY_ONE  = 8'hE0;
   localparam logic [7:0] IDX_KEY_TWO  = 8'hE1;
   localparam logic [7:0] IDX_OFF_LOW  = 8'hE2;
   localparam logic [7:0] IDX_OFF_HIGH = 8'hE3;
   localparam logic [7:0] IDX_CONTROL  = 8'hE4;
   localparam logic [7:0] IDX_WR_BYTE  = 8'hE8;
   localparam logic [7:0] IDX_STATUS   = 8'hF0;
   localparam int         BYTE_SHIFT   = 2;

   // Reset values.
   localparam logic [3:0] RST_KEY      = 4'h0;
   localparam logic [7:0] RST_OFF_LOW  = 8'hFF;
   localparam logic [3:0] RST_OFF_HIGH = 4'hF;
   localparam logic [3:0] RST_TIMING   = 4'h8;
   localparam logic [7:0] RST_WR_BYTE  = 8'h00;

   // Control register fields.
   localparam int CTL_RESERVED_ZERO_BIT = 6;
   localparam int CTL_ERASE_BIT         = 5;
   localparam int CTL_PROGRAM_BIT       = 4;

   // Status register fields.
   localparam int STS_BUSY_BIT    = 0;
   localparam int STS_ENABLED_BIT = 1;
   localparam int STS_REFUSED_BIT = 2;
   localparam int STS_ERASING_BIT = 3;

   // Key pair that opens program and erase.
   localparam logic [3:0] KEY_ONE_OPEN = 4'hA;
   localparam logic [3:0] KEY_TWO_OPEN = 4'h5;

   // Storage window: 3840 bytes, seven erasable 512-byte pages and a 256-byte tail.
   localparam logic [15:0] BASE_LARGE   = 16'hB000;
   localparam logic [15:0] BASE_SMALL   = 16'h7000;
   localparam logic [11:0] LAST_OFFSET  = 12'hEFF;
   localparam logic [3:0]  LAST_PAGE_HI = 4'hC;
   localparam logic [7:0]  PAGE_LOW     = 8'h00;
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

   // Time per timing-code step. Code 8 gives 28 us per byte, 34 ms per page.
   localparam int CLK_PERIOD_NS      = 8;
   localparam int PROG_STEP_NS       = 3500;
   localparam int ERASE_STEP_NS      = 4250000;
   localparam int PROG_STEP_CYCLES   = PROG_STEP_NS / CLK_PERIOD_NS;
   localparam int ERASE_STEP_CYCLES  = ERASE_STEP_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROGRAM,
      ST_ERASE
   } eef_state_t;

endpackage

/* design/eef_op_timer.sv */
/*
   Down-counter that measures the length of one program or erase operation.
   Assumes start_i is a one-cycle pulse and load_i is at least one.
*/
`timescale 1ns/100ps
module eef_op_timer #(
   parameter int CNT_W = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             start_i,
   input  wire logic [CNT_W-1:0] load_i,
   output logic                  done_o
);
   logic [CNT_W-1:0] count_reg;
   logic             running_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg   <= '0;
         running_reg <= 1'b0;
         done_o      <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            count_reg   <= load_i - CNT_W'(1);
            running_reg <= 1'b1;
         end else if (running_reg) begin
            if (count_reg == '0) begin
               running_reg <= 1'b0;
               done_o      <= 1'b1;
            end else begin
               count_reg <= count_reg - CNT_W'(1);
            end
         end
      end
   end
endmodule // eef_op_timer

/* tb/eef_top_monitor.sv */
/*
   Checker of eef_top ports: bus answer, operation outputs and processor clock gate.
   Assumes the larger variant's base and is bound to every eef_top.
*/
`timescale 1ns/100ps
module eef_top_monitor #(
   parameter int PROG_STEP_CYCLES  = 4,
   parameter int ERASE_STEP_CYCLES = 8
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_o,
   input  wire logic        cpu_clk_run_o,
   input  wire logic        flash_prog_o,
   input  wire logic        flash_erase_o,
   input  wire logic [15:0] flash_addr_o,
   input  wire logic [7:0]  flash_wdata_o,
   input  wire logic        busy_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 12'h390 && !wb_dat_i[6];
   // Cycles the running operation has lasted; the fall edge still sees the full count.
   int run_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i || !(flash_prog_o || flash_erase_o)) begin
         run_reg <= 0;
      end else begin
         run_reg <= run_reg + 1;
      end
   end
   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus access not answered once");
   property p_gate; flash_prog_o || flash_erase_o |-> !cpu_clk_run_o && busy_o; endproperty
   a_gate: assert property (p_gate) else $error("processor clock runs during operation");
   property p_restore; $fell(busy_o) |-> cpu_clk_run_o && !flash_prog_o && !flash_erase_o; endproperty
   a_restore: assert property (p_restore) else $error("processor clock not restored");
   property p_prog_go; $rose(flash_prog_o) |-> $rose(wb_ack_o) && $past(ctl_wr && wb_dat_i[5:4] == 2'h1); endproperty
   a_prog_go: assert property (p_prog_go) else $error("program without request");
   property p_erase_go; $rose(flash_erase_o) |-> $rose(wb_ack_o) && $past(ctl_wr && wb_dat_i[5]); endproperty
   a_erase_go: assert property (p_erase_go) else $error("erase without request");
   property p_window; flash_prog_o |-> flash_addr_o inside {[16'hB000:16'hBEFF]}; endproperty
   a_window: assert property (p_window) else $error("program outside storage window");
   property p_page; flash_erase_o |-> flash_addr_o[15:12] == 4'hB && flash_addr_o[11:9] <= 3'h6
      && flash_addr_o[8:0] == 9'h000 && flash_wdata_o == 8'hFF; endproperty
   a_page: assert property (p_page) else $error("erase of an invalid page");
   property p_hold; flash_prog_o && $past(flash_prog_o) |-> $stable(flash_addr_o) && $stable(flash_wdata_o); endproperty
   a_hold: assert property (p_hold) else $error("program target changed mid operation");
   property p_prog_len; $fell(flash_prog_o) && !$past(rst_i) |-> (run_reg - 1) % PROG_STEP_CYCLES == 0
      && run_reg > PROG_STEP_CYCLES && run_reg <= 16 * PROG_STEP_CYCLES + 1; endproperty
   a_prog_len: assert property (p_prog_len) else $error("program length off the timing code");
   property p_erase_len; $fell(flash_erase_o) && !$past(rst_i) |-> (run_reg - 1) % ERASE_STEP_CYCLES == 0
      && run_reg > ERASE_STEP_CYCLES && run_reg <= 16 * ERASE_STEP_CYCLES + 1; endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase length off the timing code");
   c_prog: cover property ($rose(flash_prog_o));
   c_erase: cover property ($rose(flash_erase_o));
   c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // eef_top_monitor

bind eef_top eef_top_monitor #(.PROG_STEP_CYCLES(PROG_STEP_CYCLES),
   .ERASE_STEP_CYCLES(ERASE_STEP_CYCLES)) eef_top_monitor_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .cpu_clk_run_o(cpu_clk_run_o), .flash_prog_o(flash_prog_o),
   .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o),
   .flash_wdata_o(flash_wdata_o), .busy_o(busy_o));

/* tb/tb_eef_top.sv */
/*
   Self-checking bench for eef_top: registers over Wishbone, program, erase, refusals.
   Assumes shortened step counts; data, and offsets and codes after the fixed first cases, come from a seeded LFSR.
*/
`timescale 1ns/100ps
module tb_eef_top;
   localparam int P = 4;
   localparam int E = 8;
   localparam logic [7:0] IDX_T [7] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE8, 8'hF0};
   localparam logic [7:0] RST_T [7] = '{8'h00, 8'h00, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00};
   localparam logic [3:0] CODE_T [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [11:0] adr = 12'h000, off;
   logic [31:0] dat = 32'h0000_0000, dat_o, rd;
   logic        ack, run, prog, erase, busy;
   logic [15:0] fadr, seed = 16'h005D;
   logic [7:0]  fdat;
   int          err_total = 0, n_compared = 0, n;
   always #4 clk_i = ~clk_i;
   eef_top #(.PROG_STEP_CYCLES(P), .ERASE_STEP_CYCLES(E)) eef_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .cpu_clk_run_o(run), .flash_prog_o(prog), .flash_erase_o(erase),
      .flash_addr_o(fadr), .flash_wdata_o(fdat), .busy_o(busy));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int op_len(input logic [3:0] code, input int step);
      return (code == 4'h0 ? 1 : int'(code)) * step + 1;
   endfunction
   task automatic end_sim();
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'h0, idx, 2'h0};
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_total++;
         end_sim();
      end
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Kind 0 expects no operation to start, 1 a byte program and 2 a page erase.
   // The block has no low-voltage reset pin; the bench stands for software that keeps it off.
   task automatic op(input logic [7:0] ctl, input logic [1:0] kind, input logic [15:0] a,
                     input logic [7:0] d);
      wb(1'b1, eef_pkg::IDX_CONTROL, ctl);
      chk({erase, prog, busy, run}, {kind, kind != 2'h0, kind == 2'h0});
      if (kind != 2'h0) begin
         chk(fadr, a);
         chk(fdat, d);
         n = 0;
         while ((prog | erase) === 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
         end
         if (n == 200) begin
            err_total++;
            end_sim();
         end
         chk(n, op_len(ctl[3:0], kind[1] ? E : P));
         chk(run, 1'b1);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, IDX_T[i], 8'h00);
         chk(rd, {24'h0, RST_T[i]});
      end
      op(8'h11, 2'h0, 16'h0, 8'h0);
      wb(1'b0, eef_pkg::IDX_STATUS, 8'h00);
      chk(rd, 32'h1 << eef_pkg::STS_REFUSED_BIT);
      wb(1'b1, eef_pkg::IDX_STATUS, 8'h04);
      wb(1'b0, eef_pkg::IDX_STATUS, 8'h00);
      chk(rd, 32'h0000_0000);
      wb(1'b1, eef_pkg::IDX_KEY_ONE, 8'hFA);
      wb(1'b1, eef_pkg::IDX_KEY_TWO, 8'hFA);
      op(8'h11, 2'h0, 16'h0, 8'h0);
      // Upper key bits are unimplemented, so these still open the pair.
      wb(1'b1, eef_pkg::IDX_KEY_TWO, 8'hC5);
      wb(1'b0, eef_pkg::IDX_STATUS, 8'h00);
      chk(rd, (32'h1 << eef_pkg::STS_ENABLED_BIT) | (32'h1 << eef_pkg::STS_REFUSED_BIT));
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         off = i == 0 ? 12'h000 : i == 1 ? 12'hEFF : seed[11:0] % 12'hF00;
         wb(1'b1, eef_pkg::IDX_OFF_LOW, off[7:0]);
         wb(1'b1, eef_pkg::IDX_OFF_HIGH, {4'hA, off[11:8]});
         wb(1'b0, eef_pkg::IDX_OFF_HIGH, 8'h00);
         chk(rd, {28'h0, off[11:8]});
         wb(1'b1, eef_pkg::IDX_WR_BYTE, seed[15:8]);
         op({4'h1, i < 4 ? CODE_T[i] : seed[3:0]}, 2'h1, 16'hB000 + 16'(off), seed[15:8]);
      end
      wb(1'b1, eef_pkg::IDX_OFF_HIGH, 8'h0F);
      op(8'h18, 2'h0, 16'h0, 8'h0);
      wb(1'b1, eef_pkg::IDX_OFF_LOW, 8'h00);
      for (int p = 0; p < 7; p++) begin
         wb(1'b1, eef_pkg::IDX_OFF_HIGH, 8'(2 * p));
         op(p == 6 ? 8'h31 : 8'h21, 2'h2, 16'hB000 + 16'(p * 512), 8'hFF);
      end
      wb(1'b1, eef_pkg::IDX_OFF_HIGH, 8'h03);
      op(8'h21, 2'h0, 16'h0, 8'h0);
      wb(1'b1, eef_pkg::IDX_OFF_HIGH, 8'h0E);
      op(8'h21, 2'h0, 16'h0, 8'h0);
      wb(1'b1, eef_pkg::IDX_OFF_HIGH, 8'h00);
      op(8'h51, 2'h0, 16'h0, 8'h0);
      end_sim();
   end
endmodule // tb_eef_top
